// file: verilog/iflag_pkg.sv
// Package for the interrupt flag set/clear unit.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package iflag_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [7:0] IFLAG_IDX_FLAGS_LOW = 8'h06;
  localparam logic [7:0] IFLAG_IDX_FLAGS_HIGH = 8'h07;
  localparam logic [7:0] IFLAG_IDX_EN_LOW = 8'h08;
  localparam logic [7:0] IFLAG_IDX_EN_HIGH = 8'h09;
  localparam logic [11:0] IFLAG_ADDR_FLAGS_LOW = {2'h0, IFLAG_IDX_FLAGS_LOW, 2'h0};
  localparam logic [11:0] IFLAG_ADDR_FLAGS_HIGH = {2'h0, IFLAG_IDX_FLAGS_HIGH, 2'h0};
  localparam logic [11:0] IFLAG_ADDR_EN_LOW = {2'h0, IFLAG_IDX_EN_LOW, 2'h0};
  localparam logic [11:0] IFLAG_ADDR_EN_HIGH = {2'h0, IFLAG_IDX_EN_HIGH, 2'h0};

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int IFLAG_SET_BIT = 7;
  localparam int IFLAG_GLOBAL_BIT = 6;
  localparam int IFLAG_INV_BIT = 7;
  localparam int IFLAG_DRIVE_BIT = 7;
  localparam int IFLAG_PINEN_BIT = 6;
  localparam logic [6:0] IFLAG_LOW_MASK = 7'h7F;
  localparam logic [6:0] IFLAG_HIGH_MASK = 7'h3F;
  localparam logic [7:0] IFLAG_FLAGS_RST = 8'h00;
  localparam logic [7:0] IFLAG_EN_RST = 8'h00;

  // ****************************************
  // Event inputs from the rest of the frontend
  // ****************************************
  typedef struct packed {
    logic hi_alert;
    logic lo_alert;
    logic cmd_done;
    logic tx_done;
    logic rx_done;
    logic [4:0] err;
    logic rx_sof;
    logic card_detect;
    logic [4:0] timer_uflow;
  } iflag_events_type;

endpackage

// file: verilog/iflag_unit.sv
// Interrupt flag, enable and pin logic with an APB register slave.
// Assumes event inputs are synchronous pulses or levels on pclk.
//
// Functional notes
// RQ1 - Write with bit7=1 sets, bit7=0 clears, each flag written as 1.
// RQ2 - FFh sets all low flags, 7Fh clears all low flags.
// RQ3 - High register set/clear acts on bits 5..0; bit 6 global only.
// RQ4 - Low flag register at 06h, resets to 00h.
// RQ5 - High-level alert flag latches live alert, holds until cleared.
// RQ6 - Low-level alert flag latches live alert, holds until cleared.
// RQ7 - Idle flag set when running command ends by itself.
// RQ8 - Unknown command reverts to idle and sets idle flag.
// RQ9 - Host starting idle command does not set idle flag.
// RQ10 - Transmit flag set right after last bit sent.
// RQ11 - Receive flag set at end of stream, whatever its correctness.
// RQ12 - Error flag set when any of five error indications sets.
// RQ13 - Frame start flag set on start-of-frame or subcarrier.
// RQ14 - Global request set when any enabled flag is active.
// RQ15 - Card detect flag set when low-power detection finds card.
// RQ16 - Five timer flags set on their timer underflow.
// RQ17 - Enable register at 08h: polarity bit7, enables bits 6..0.
// RQ18 - Polarity bit inverts interrupt pin level.
// RQ19 - Flag counts toward global request only while enabled.
// RQ20 - Pin enable gates global request; drive-mode picks push-pull or open-drain.
// RQ21 - Bit 7 of request registers reads 0; global recomputed each clock.
module iflag_unit
  import iflag_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources
  input wire iflag_events_type events,
  // Command field handshake
  input wire logic cmd_start,
  input wire logic cmd_known,
  input wire logic cmd_is_idle,
  output logic cmd_revert,
  // Interrupt pin
  output logic irq_pin_out,
  output logic irq_pin_oe,
  output logic global_request
);

  // ****************************************
  // Registers
  // ****************************************
  logic [6:0] flags_low;
  logic [5:0] flags_high;
  logic high_level_alert_flag;
  logic low_level_alert_flag;
  logic command_idle_flag;
  logic transmit_done_flag;
  logic receive_done_flag;
  logic error_summary_flag;
  logic frame_start_flag;
  logic card_detect_flag;
  logic timer_four_underflow_flag;
  logic timer_three_underflow_flag;
  logic timer_two_underflow_flag;
  logic timer_one_underflow_flag;
  logic timer_zero_underflow_flag;
  logic [7:0] en_low_r;
  logic [7:0] en_high_r;
  logic [4:0] err_prev_r;
  logic cmd_done_nxt;

  logic wr_en;
  logic rd_setup;
  logic sel_low;
  logic sel_high;
  logic sel_en_low;
  logic sel_en_high;
  logic addr_ok;
  logic [6:0] low_hw_set;
  logic [5:0] high_hw_set;
  logic [6:0] low_wr_set;
  logic [6:0] low_wr_clr;
  logic [5:0] high_wr_set;
  logic [5:0] high_wr_clr;
  logic wr_set_mode;
  logic global_nxt;
  logic pin_level;

  // ****************************************
  // Bus decode
  // ****************************************
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign sel_low = (paddr == IFLAG_ADDR_FLAGS_LOW);
  assign sel_high = (paddr == IFLAG_ADDR_FLAGS_HIGH);
  assign sel_en_low = (paddr == IFLAG_ADDR_EN_LOW);
  assign sel_en_high = (paddr == IFLAG_ADDR_EN_HIGH);
  assign addr_ok = sel_low | sel_high | sel_en_low | sel_en_high;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_set_mode = pwdata[IFLAG_SET_BIT];

  // ****************************************
  // Event capture
  // ****************************************
  // Unknown command reverts to idle and counts as self-termination
  assign cmd_revert = cmd_start & ~cmd_known & ~cmd_is_idle; // [RQ8]
  // Host-started idle is excluded; only self-ends count
  assign cmd_done_nxt = (events.cmd_done & ~(cmd_start & cmd_is_idle)) | cmd_revert; // [RQ7] [RQ9]

  assign low_hw_set = {
    events.hi_alert, // [RQ5]
    events.lo_alert, // [RQ6]
    cmd_done_nxt, // [RQ7] [RQ8]
    events.tx_done, // [RQ10]
    events.rx_done, // [RQ11]
    |(events.err & ~err_prev_r), // [RQ12]
    events.rx_sof // [RQ13]
  };
  assign high_hw_set = {events.card_detect, events.timer_uflow}; // [RQ15] [RQ16]

  // Rising edges of the error indications only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_prev_r <= 5'h00;
    end else begin
      err_prev_r <= events.err;
    end
  end

  // ****************************************
  // Software set/clear
  // ****************************************
  assign low_wr_set = (wr_en & sel_low & wr_set_mode) ? (pwdata[6:0] & IFLAG_LOW_MASK) : 7'h00; // [RQ1] [RQ2]
  assign low_wr_clr = (wr_en & sel_low & ~wr_set_mode) ? (pwdata[6:0] & IFLAG_LOW_MASK) : 7'h00; // [RQ1] [RQ2]
  assign high_wr_set = (wr_en & sel_high & wr_set_mode) ? pwdata[5:0] : 6'h00; // [RQ3]
  assign high_wr_clr = (wr_en & sel_high & ~wr_set_mode) ? pwdata[5:0] : 6'h00; // [RQ3]

  // Hardware set wins over a simultaneous software clear
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[6])
  ) cell_hi_alert_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[6]),
    .sw_set(low_wr_set[6]),
    .sw_clr(low_wr_clr[6]),
    .flag(high_level_alert_flag)
  ); // [RQ4] [RQ5]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[5])
  ) cell_lo_alert_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[5]),
    .sw_set(low_wr_set[5]),
    .sw_clr(low_wr_clr[5]),
    .flag(low_level_alert_flag)
  ); // [RQ4] [RQ6]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[4])
  ) cell_idle_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[4]),
    .sw_set(low_wr_set[4]),
    .sw_clr(low_wr_clr[4]),
    .flag(command_idle_flag)
  ); // [RQ7]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[3])
  ) cell_tx_done_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[3]),
    .sw_set(low_wr_set[3]),
    .sw_clr(low_wr_clr[3]),
    .flag(transmit_done_flag)
  ); // [RQ10]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[2])
  ) cell_rx_done_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[2]),
    .sw_set(low_wr_set[2]),
    .sw_clr(low_wr_clr[2]),
    .flag(receive_done_flag)
  ); // [RQ11]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[1])
  ) cell_error_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[1]),
    .sw_set(low_wr_set[1]),
    .sw_clr(low_wr_clr[1]),
    .flag(error_summary_flag)
  ); // [RQ12]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[0])
  ) cell_frame_start_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(low_hw_set[0]),
    .sw_set(low_wr_set[0]),
    .sw_clr(low_wr_clr[0]),
    .flag(frame_start_flag)
  ); // [RQ13]

  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[5])
  ) cell_card_detect_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(high_hw_set[5]),
    .sw_set(high_wr_set[5]),
    .sw_clr(high_wr_clr[5]),
    .flag(card_detect_flag)
  ); // [RQ15]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[4])
  ) cell_timer_four_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(high_hw_set[4]),
    .sw_set(high_wr_set[4]),
    .sw_clr(high_wr_clr[4]),
    .flag(timer_four_underflow_flag)
  ); // [RQ16]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[3])
  ) cell_timer_three_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(high_hw_set[3]),
    .sw_set(high_wr_set[3]),
    .sw_clr(high_wr_clr[3]),
    .flag(timer_three_underflow_flag)
  ); // [RQ16]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[2])
  ) cell_timer_two_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(high_hw_set[2]),
    .sw_set(high_wr_set[2]),
    .sw_clr(high_wr_clr[2]),
    .flag(timer_two_underflow_flag)
  ); // [RQ16]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[1])
  ) cell_timer_one_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(high_hw_set[1]),
    .sw_set(high_wr_set[1]),
    .sw_clr(high_wr_clr[1]),
    .flag(timer_one_underflow_flag)
  ); // [RQ16]
  iflag_flag_cell #(
    .RST_VALUE(IFLAG_FLAGS_RST[0])
  ) cell_timer_zero_i (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(high_hw_set[0]),
    .sw_set(high_wr_set[0]),
    .sw_clr(high_wr_clr[0]),
    .flag(timer_zero_underflow_flag)
  ); // [RQ16]

  assign flags_low = {high_level_alert_flag, low_level_alert_flag, command_idle_flag, transmit_done_flag,
    receive_done_flag, error_summary_flag, frame_start_flag};
  assign flags_high = {card_detect_flag, timer_four_underflow_flag, timer_three_underflow_flag,
    timer_two_underflow_flag, timer_one_underflow_flag, timer_zero_underflow_flag};

  // ****************************************
  // Enable registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_low_r <= IFLAG_EN_RST;
    end else if (wr_en & sel_en_low) begin
      en_low_r <= pwdata[7:0]; // [RQ17]
    end
  end

  // Second enable register laid out as polarity-free pin control plus enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_high_r <= IFLAG_EN_RST;
    end else if (wr_en & sel_en_high) begin
      en_high_r <= pwdata[7:0];
    end
  end

  // ****************************************
  // Global request and pin
  // ****************************************
  assign global_nxt = |(flags_low & en_low_r[6:0]) | |(flags_high & en_high_r[5:0]); // [RQ14] [RQ19]

  // Recomputed each clock from current flags and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_request <= 1'b0;
    end else begin
      global_request <= global_nxt; // [RQ21]
    end
  end

  assign pin_level = en_high_r[IFLAG_PINEN_BIT] & global_request; // [RQ20]

  // Open-drain only pulls the line; the high level comes from outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin_out <= 1'b0;
      irq_pin_oe <= 1'b0;
    end else if (en_high_r[IFLAG_DRIVE_BIT]) begin
      irq_pin_out <= pin_level ^ en_low_r[IFLAG_INV_BIT]; // [RQ18] [RQ20]
      irq_pin_oe <= 1'b1;
    end else begin
      irq_pin_out <= 1'b0;
      irq_pin_oe <= ~(pin_level ^ en_low_r[IFLAG_INV_BIT]); // [RQ18] [RQ20]
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (paddr == IFLAG_ADDR_FLAGS_LOW) begin
        prdata <= {25'h0000000, flags_low}; // [RQ21]
      end else if (paddr == IFLAG_ADDR_FLAGS_HIGH) begin
        prdata <= {24'h000000, 1'b0, global_request, flags_high}; // [RQ21] [RQ3]
      end else if (paddr == IFLAG_ADDR_EN_LOW) begin
        prdata <= {24'h000000, en_low_r};
      end else if (paddr == IFLAG_ADDR_EN_HIGH) begin
        prdata <= {24'h000000, en_high_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ****************************************
// One latched request flag
// ****************************************
// Set beats clear so that an event in the clearing cycle is not lost
module iflag_flag_cell #(
  parameter logic RST_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear requests
  input wire logic hw_set,
  input wire logic sw_set,
  input wire logic sw_clr,
  // Stored flag
  output logic flag
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= RST_VALUE;
    end else if (hw_set | sw_set) begin
      flag <= 1'b1;
    end else if (sw_clr) begin
      flag <= 1'b0;
    end
  end

endmodule

// file: sim/iflag_pin_host.sv
// Host side of the interrupt line.
// Assumes a board pull-up on the line.
module iflag_pin_host (
  // Pin drive
  input wire logic pin_out,
  input wire logic pin_oe,
  // Level seen by the host
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  assign line = pin_oe ? pin_out : 1'b1;
endmodule

// file: sim/iflag_sva.sv
// Port checker for the interrupt flag unit.
// Assumes it is bound to iflag_unit.
module iflag_sva
  import iflag_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire iflag_events_type events,
  input wire logic cmd_start,
  input wire logic cmd_known,
  input wire logic cmd_is_idle,
  input wire logic cmd_revert,
  input wire logic global_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, wr, mapped, cause, flagreg;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign flagreg = paddr inside {IFLAG_ADDR_FLAGS_LOW, IFLAG_ADDR_FLAGS_HIGH};
  assign mapped = flagreg || paddr inside {IFLAG_ADDR_EN_LOW, IFLAG_ADDR_EN_HIGH};
  // Only events, writes or command starts may raise the request, two edges on
  assign cause = (|events) || wr || cmd_start;
  apb_ready_a: assert property (acc |-> pready) else $error("no ready");
  apb_err_a: assert property (acc |-> pslverr == !mapped) else $error("bad slverr");
  read_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
  set_bit_a: assert property (acc && !pwrite && flagreg |-> !prdata[7]) else $error("bit 7 read");
  cmd_revert_a: assert property (cmd_revert == (cmd_start && !cmd_known && !cmd_is_idle)) else $error("bad revert");
  glob_cause_a: assert property ($rose(global_request) |-> $past(cause, 2)) else $error("no cause");
  glob_fall_a: assert property ($fell(global_request) |-> $past(wr, 2)) else $error("bad fall");
  glob_hold_a: assert property (global_request && !wr && !$past(wr) |=> global_request)
    else $error("lost request");
  cover property ($rose(global_request));
  cover property (cmd_revert);
  cover property (acc && pslverr);
endmodule

// file: sim/testbench.sv
// Self-checking bench for the interrupt flag unit.
// Assumes the checker and pin host model are compiled first.
module testbench
  import iflag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic cmd_start = 0, cmd_known = 0, cmd_is_idle = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, cmd_revert, irq_pin_out, irq_pin_oe, global_request, line, slv;
  iflag_events_type events = '0;
  int errors = 0, check_count = 0, seed = 73, fl = 0, fh = 0, el = 0, eh = 0, v;
  iflag_unit iflag_unit_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .events(events),
    .cmd_start(cmd_start),
    .cmd_known(cmd_known),
    .cmd_is_idle(cmd_is_idle),
    .cmd_revert(cmd_revert),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe),
    .global_request(global_request)
  );
  iflag_pin_host iflag_pin_host_i (.pin_out(irq_pin_out), .pin_oe(irq_pin_oe), .line(line));
  initial forever #12.5 pclk = ~pclk;
  task automatic conclude;
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d[7:0]};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      conclude;
    end
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Model follows each write; bit 6 of the high flags is never stored
  task automatic wflag(input logic [11:0] a, input int d);
    xfer(1, a, d);
    if (a == IFLAG_ADDR_FLAGS_LOW) fl = d[7] ? fl | d & 'h7F : fl & ~d;
    else fh = d[7] ? fh | d & 'h3F : fh & ~d & 'h3F;
  endtask
  task automatic wen(input logic [11:0] a, input int d);
    xfer(1, a, d);
    if (a == IFLAG_ADDR_EN_LOW) el = d & 'hFF; else eh = d & 'hFF;
  endtask
  task automatic verify;
    repeat (3) @(posedge pclk);
    xfer(0, IFLAG_ADDR_FLAGS_LOW, 0);
    chk("flags_low", fl, rd);
    v = (fl & el & 'h7F) != 0 || (fh & eh & 'h3F) != 0;
    xfer(0, IFLAG_ADDR_FLAGS_HIGH, 0);
    chk("flags_high", fh | v << 6, rd);
    chk("global", v, global_request);
    chk("pin", (v && eh[6]) ^ el[7], line);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    verify;
    xfer(0, 12'h3FC, 0);
    chk("unmapped", 0, rd);
    chk("slverr", 1, slv);
    wflag(IFLAG_ADDR_FLAGS_LOW, 'hFF); verify;
    wflag(IFLAG_ADDR_FLAGS_LOW, 'h7F); verify;
    for (int i = 0; i < 12; i++) begin
      wen(IFLAG_ADDR_EN_LOW, $random(seed));
      wen(IFLAG_ADDR_EN_HIGH, $random(seed));
      wflag(IFLAG_ADDR_FLAGS_LOW, $random(seed));
      wflag(IFLAG_ADDR_FLAGS_HIGH, $random(seed));
      verify;
      xfer(0, IFLAG_ADDR_EN_LOW, 0);
      chk("en_low", el, rd);
      xfer(0, IFLAG_ADDR_EN_HIGH, 0);
      chk("en_high", eh, rd);
    end
    wen(IFLAG_ADDR_EN_LOW, 'h7F);
    wen(IFLAG_ADDR_EN_HIGH, 'h7F);
    // One event per pass, dropped before the read to prove latching
    for (int i = 0; i < 17; i++) begin
      wflag(IFLAG_ADDR_FLAGS_LOW, 'h7F);
      wflag(IFLAG_ADDR_FLAGS_HIGH, 'h7F);
      @(posedge pclk);
      events <= iflag_events_type'(17'h1 << i);
      @(posedge pclk);
      events <= '0;
      if (i < 6) fh = 1 << i; else fl = 1 << (i < 7 ? 0 : i < 12 ? 1 : i - 10);
      verify;
    end
    wflag(IFLAG_ADDR_FLAGS_LOW, 'h7F);
    @(posedge pclk);
    {cmd_start, cmd_known, cmd_is_idle} <= 3'h7;
    events.cmd_done <= 1;
    @(posedge pclk);
    chk("cmd_revert", 0, cmd_revert);
    {cmd_start, cmd_known, cmd_is_idle} <= 3'h0;
    events.cmd_done <= 0;
    verify;
    @(posedge pclk);
    cmd_start <= 1;
    @(posedge pclk);
    chk("cmd_revert", 1, cmd_revert);
    cmd_start <= 0;
    fl = 'h10;
    verify;
    conclude;
  end
  initial begin
    #200us;
    errors++;
    conclude;
  end
endmodule
bind iflag_unit iflag_sva iflag_sva_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .events(events),
  .cmd_start(cmd_start),
  .cmd_known(cmd_known),
  .cmd_is_idle(cmd_is_idle),
  .cmd_revert(cmd_revert),
  .global_request(global_request)
);
